// ### rtl/dsmp_defines.svh
`ifndef DSMP_DEFINES_SVH
`define DSMP_DEFINES_SVH

// ----------------------------------------------------------------------------
// register select codes (low bits of the ten-bit register address)
// ----------------------------------------------------------------------------
`define DSMP_SEL_B_REGION   2'b10          // narrow map: region-base
`define DSMP_SEL_B_CTRL     2'b11          // narrow map: control
`define DSMP_SEL_A_REGION   4'b0110        // shared map: region-base
`define DSMP_SEL_A_CTRL     4'b0111        // shared map: control

// ----------------------------------------------------------------------------
// field positions (bit 0 is the most significant bit)
// ----------------------------------------------------------------------------
`define DSMP_CTRL_DECODE_EN 0              // control bit that enables decoding
`define DSMP_ADDR_TOP_MSB   0              // first compared processor address bit
`define DSMP_ADDR_TOP_LSB   7              // last compared processor address bit

// ----------------------------------------------------------------------------
// reset values and clock ratio limits
// ----------------------------------------------------------------------------
`define DSMP_REG_RST        8'h00
`define DSMP_DATA_RST       32'h0000_0000
`define DSMP_RATIO_MIN      4'h1
`define DSMP_RATIO_MAX_A    4'h8
`define DSMP_RATIO_MAX_B    4'h4

`endif

// ### rtl/dsmp_pkg.sv
package dsmp_pkg;

  // ----------------------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DSMP_IDLE   = 2'b00,
    DSMP_BUSY   = 2'b01,
    DSMP_RETIRE = 2'b10
  } dsmp_state_e;

  typedef logic [0:7]  dsmp_byte_t;
  typedef logic [0:31] dsmp_word_t;

endpackage

// ### rtl/dsmp_port.sv
`timescale 1ns/1ps
`include "dsmp_defines.svh"

// Overview of operation
// - The memory-side clock runs this port and the fabric memory, at a cpu ratio of 1 to 8 (A) or 1 to 4 (B).
// - In variant A an access lasts any whole number of cycles and ends only on the completion input.
// - No new access starts before the current one has ended: on its completion in variant A, after one busy cycle in variant B.
// - Attribute inputs load the registers at power-up and after every processor reset.
// - The control register starts from its 8-bit init input and software writes replace it.
// - The region-base register starts from its 8-bit init input and places the 16 MB space.
// - In variant B eight tie bits plus low bits 10 and 11 address region-base and control.
// - In variant A six tie bits plus low bits 0110 and 0111 address region-base and control.
// - An access is claimed only if the top eight address bits match region-base and decoding is on.
// - A pending load is served before a pending store.
module dsmp_port
  import dsmp_pkg::*;
(
  input  wire logic              CLK,                // memory-side clock
  input  wire logic              RST_B,              // async reset, active low
  input  wire logic              PROC_RESET,         // processor reset, reloads registers
  input  wire logic              VARIANT_A,          // strap: high for variant A
  input  wire logic [3:0]        CLOCK_RATIO,        // strap: cpu to memory clock ratio
  output logic                   RATIO_OK,           // ratio within variant limits
  input  wire dsmp_pkg::dsmp_byte_t CTRL_INIT_VALUE,    // control register init value
  input  wire dsmp_pkg::dsmp_byte_t REGION_INIT_VALUE,  // region-base init value
  input  wire dsmp_pkg::dsmp_byte_t REG_ADDR_HI_EIGHT,  // register address top, variant B
  input  wire logic [0:5]        REG_ADDR_HI_SIX,    // register address top, variant A
  input  wire logic [0:9]        DCR_ADDR,           // register bus address
  input  wire logic              DCR_READ,           // register read strobe
  input  wire logic              DCR_WRITE,          // register write strobe
  input  wire dsmp_pkg::dsmp_byte_t DCR_WR_DATA,        // register write data
  output dsmp_pkg::dsmp_byte_t   DCR_RD_DATA,        // register read data
  output logic                   DCR_ACK,            // register access taken
  output dsmp_pkg::dsmp_byte_t   CTRL_VALUE,         // current control register
  output dsmp_pkg::dsmp_byte_t   REGION_VALUE,       // current region-base register
  input  wire logic              CPU_LOAD_REQ,       // load pending, held until answered
  input  wire dsmp_pkg::dsmp_word_t CPU_LOAD_ADDR,      // load address
  input  wire logic              CPU_STORE_REQ,      // store pending, held until answered
  input  wire dsmp_pkg::dsmp_word_t CPU_STORE_ADDR,     // store address
  output logic                   CPU_LOAD_DONE,      // load finished, data valid
  output logic                   CPU_STORE_DONE,     // store finished
  output logic                   CPU_LOAD_MISS,      // load not claimed
  output logic                   CPU_STORE_MISS,     // store not claimed
  output dsmp_pkg::dsmp_word_t   CPU_LOAD_DATA,      // captured load data
  output logic                   ACCESS_START,       // one-cycle start to the fabric
  output logic                   ACCESS_WRITE,       // started access is a store
  output logic                   ACCESS_BUSY,        // access outstanding
  input  wire dsmp_pkg::dsmp_word_t FABRIC_READ_DATA,   // read data from the fabric
  input  wire logic              ACCESS_DONE_PULSE   // completion from the fabric
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  dsmp_state_e state_r;
  dsmp_state_e state_nxt;
  dsmp_byte_t  ctrl_r;
  dsmp_byte_t  region_r;
  logic        init_pend_r;
  logic        variant_a_r;
  logic        ratio_ok_r;
  logic        is_write_r;
  logic        start_r;
  logic        ld_done_r;
  logic        st_done_r;
  logic        ld_miss_r;
  logic        st_miss_r;
  dsmp_word_t  ld_data_r;
  dsmp_byte_t  rd_data_r;
  logic        ack_r;
  logic        hit_region;
  logic        hit_ctrl;
  logic        ld_claim;
  logic        st_claim;
  logic        fab_done;
  logic        go_load;
  logic        go_store;
  logic        go_miss;
  logic        reload;
  logic        bus_ok;

  // ----------------------------------------------------------------------------
  // register address decode
  // ----------------------------------------------------------------------------
  dsmp_reg_decode u_decode (
    .addr       (DCR_ADDR),
    .hi_eight   (REG_ADDR_HI_EIGHT),
    .hi_six     (REG_ADDR_HI_SIX),
    .variant_a  (variant_a_r),
    .hit_region (hit_region),
    .hit_ctrl   (hit_ctrl)
  );

  // ----------------------------------------------------------------------------
  // strap capture and register load
  // ----------------------------------------------------------------------------
  // reload on the first edge after reset and on processor reset
  assign reload = init_pend_r || PROC_RESET;

  // power-up load pending until the first edge after release
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      init_pend_r <= 1'b1;
    end else begin
      init_pend_r <= 1'b0;
    end
  end

  // straps caught by a clocked load, never by the reset itself
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      variant_a_r <= 1'b0;
      ratio_ok_r  <= 1'b0;
    end else if (reload) begin
      variant_a_r <= VARIANT_A;
      // ratio range depends on the variant
      ratio_ok_r  <= (CLOCK_RATIO >= `DSMP_RATIO_MIN) &&
                     (CLOCK_RATIO <= (VARIANT_A ? `DSMP_RATIO_MAX_A : `DSMP_RATIO_MAX_B));
    end
  end

  // control register: init value, then software writes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= `DSMP_REG_RST;
    end else if (reload) begin
      ctrl_r <= CTRL_INIT_VALUE;
    end else if (DCR_WRITE && hit_ctrl) begin
      ctrl_r <= DCR_WR_DATA;
    end
  end

  // region-base register: init value, then software writes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      region_r <= `DSMP_REG_RST;
    end else if (reload) begin
      region_r <= REGION_INIT_VALUE;
    end else if (DCR_WRITE && hit_region) begin
      region_r <= DCR_WR_DATA;
    end
  end

  // ----------------------------------------------------------------------------
  // register bus answer
  // ----------------------------------------------------------------------------
  // only a decoded address is acknowledged; others are left to other slaves
  assign bus_ok = (DCR_READ || DCR_WRITE) && (hit_region || hit_ctrl) && !reload;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_r     <= 1'b0;
      rd_data_r <= `DSMP_REG_RST;
    end else begin
      ack_r <= bus_ok;
      if (DCR_READ && bus_ok) begin
        rd_data_r <= hit_ctrl ? ctrl_r : region_r;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------------------
  // claim on region match with decoding enabled
  assign ld_claim = ctrl_r[`DSMP_CTRL_DECODE_EN] &&
                    (CPU_LOAD_ADDR[`DSMP_ADDR_TOP_MSB:`DSMP_ADDR_TOP_LSB] == region_r);
  assign st_claim = ctrl_r[`DSMP_CTRL_DECODE_EN] &&
                    (CPU_STORE_ADDR[`DSMP_ADDR_TOP_MSB:`DSMP_ADDR_TOP_LSB] == region_r);

  // load wins when both are pending
  assign go_load  = (state_r == DSMP_IDLE) && !reload && CPU_LOAD_REQ && ld_claim;
  assign go_store = (state_r == DSMP_IDLE) && !reload && !CPU_LOAD_REQ &&
                    CPU_STORE_REQ && st_claim;
  assign go_miss  = (state_r == DSMP_IDLE) && !reload && !go_load && !go_store &&
                    (CPU_LOAD_REQ || CPU_STORE_REQ);

  // variant A waits for completion; variant B ends after one cycle
  assign fab_done = (state_r == DSMP_BUSY) && (!variant_a_r || ACCESS_DONE_PULSE);

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DSMP_IDLE: begin
        if (go_load || go_store) begin
          state_nxt = DSMP_BUSY;
        end else if (go_miss) begin
          state_nxt = DSMP_RETIRE;
        end
      end
      DSMP_BUSY: begin
        // hold until the current access completes
        if (fab_done) begin
          state_nxt = DSMP_RETIRE;
        end
      end
      DSMP_RETIRE: begin
        state_nxt = DSMP_IDLE;
      end
      default: begin
        state_nxt = DSMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= DSMP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // start pulse and access direction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      start_r    <= 1'b0;
      is_write_r <= 1'b0;
    end else begin
      start_r <= go_load || go_store;
      if (go_load || go_store) begin
        is_write_r <= go_store;
      end
    end
  end

  // answers to the processor, one cycle each
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ld_done_r <= 1'b0;
      st_done_r <= 1'b0;
      ld_miss_r <= 1'b0;
      st_miss_r <= 1'b0;
    end else begin
      ld_done_r <= fab_done && !is_write_r;
      st_done_r <= fab_done && is_write_r;
      ld_miss_r <= go_miss && CPU_LOAD_REQ;
      st_miss_r <= go_miss && !CPU_LOAD_REQ;
    end
  end

  // load data captured in the completion cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ld_data_r <= `DSMP_DATA_RST;
    end else if (fab_done && !is_write_r) begin
      ld_data_r <= FABRIC_READ_DATA;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign RATIO_OK       = ratio_ok_r;
  assign DCR_RD_DATA    = rd_data_r;
  assign DCR_ACK        = ack_r;
  assign CTRL_VALUE     = ctrl_r;
  assign REGION_VALUE   = region_r;
  assign CPU_LOAD_DONE  = ld_done_r;
  assign CPU_STORE_DONE = st_done_r;
  assign CPU_LOAD_MISS  = ld_miss_r;
  assign CPU_STORE_MISS = st_miss_r;
  assign CPU_LOAD_DATA  = ld_data_r;
  assign ACCESS_START   = start_r;
  assign ACCESS_WRITE   = is_write_r;
  assign ACCESS_BUSY    = (state_r == DSMP_BUSY);

endmodule

// ### rtl/dsmp_reg_decode.sv
`timescale 1ns/1ps
`include "dsmp_defines.svh"

module dsmp_reg_decode
  import dsmp_pkg::*;
(
  input  wire logic [0:9] addr,       // register bus address
  input  wire logic [0:7] hi_eight,   // upper eight address bits, narrow map
  input  wire logic [0:5] hi_six,     // upper six address bits, shared map
  input  wire logic       variant_a,  // high selects the shared map
  output logic            hit_region, // address selects region-base register
  output logic            hit_ctrl    // address selects control register
);

  // ----------------------------------------------------------------------------
  // address match
  // ----------------------------------------------------------------------------
  logic hi_ok_b;
  logic hi_ok_a;

  // upper bits of each map compared against the tie inputs
  assign hi_ok_b = (addr[0:7] == hi_eight);
  assign hi_ok_a = (addr[0:5] == hi_six);

  // select register from the low bits of the active map
  always_comb begin
    if (variant_a) begin
      hit_region = hi_ok_a && (addr[6:9] == `DSMP_SEL_A_REGION);
      hit_ctrl   = hi_ok_a && (addr[6:9] == `DSMP_SEL_A_CTRL);
    end else begin
      hit_region = hi_ok_b && (addr[8:9] == `DSMP_SEL_B_REGION);
      hit_ctrl   = hi_ok_b && (addr[8:9] == `DSMP_SEL_B_CTRL);
    end
  end

endmodule

// ### testbench/dsmp_fabric_model.sv
`timescale 1ns/1ps

module dsmp_fabric_model
  import dsmp_pkg::*;
(
  input  wire logic                 clk,      // memory-side clock
  input  wire logic                 rst_b,    // async reset, active low
  input  wire logic                 start,    // access begins
  input  wire logic [3:0]           delay,    // extra wait cycles
  input  wire logic                 tie_high, // fixed one-cycle memory
  input  wire logic                 stray,    // send an unsolicited completion
  input  wire dsmp_pkg::dsmp_word_t word,     // word returned on completion
  output dsmp_pkg::dsmp_word_t      rd_data,  // read data to the port
  output logic                      done      // completion pulse
);
  logic [3:0] wait_r;
  logic       pend_r;
  logic       done_r;
  dsmp_word_t data_r;

  // one pulse per access with data, always answered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 4'h0;
      pend_r <= 1'h0;
      done_r <= 1'h0;
      data_r <= 32'h0000_0000;
    end else begin
      done_r <= 1'h0;
      data_r <= ~data_r; // no stale data between pulses
      if (start && delay == 4'h0 || pend_r && wait_r == 4'h1 || stray) begin
        done_r <= 1'h1;
        data_r <= stray ? ~word : word;
      end
      if (start) begin
        pend_r <= (delay != 4'h0);
        wait_r <= delay;
      end else if (pend_r) begin
        wait_r <= wait_r - 4'h1;
        pend_r <= (wait_r != 4'h1);
      end
    end
  end

  assign done    = tie_high | done_r;
  assign rd_data = tie_high ? word : data_r;
endmodule

// ### testbench/dsmp_port_asserts.sv
`timescale 1ns/1ps

module dsmp_port_asserts
  import dsmp_pkg::*;
(
  input wire logic                 CLK,               // memory-side clock
  input wire logic                 RST_B,             // async reset
  input wire logic                 PROC_RESET,        // processor reset
  input wire logic                 VARIANT_A,         // variant strap
  input wire dsmp_pkg::dsmp_byte_t CTRL_INIT_VALUE,   // control init
  input wire dsmp_pkg::dsmp_byte_t REGION_INIT_VALUE, // region init
  input wire logic                 DCR_READ,          // reg read
  input wire logic                 DCR_WRITE,         // reg write
  input wire logic                 DCR_ACK,           // reg ack
  input wire dsmp_pkg::dsmp_byte_t CTRL_VALUE,        // control reg
  input wire dsmp_pkg::dsmp_byte_t REGION_VALUE,      // region reg
  input wire logic                 CPU_LOAD_REQ,      // load pending
  input wire dsmp_pkg::dsmp_word_t CPU_LOAD_ADDR,     // load address
  input wire logic                 CPU_STORE_REQ,     // store pending
  input wire dsmp_pkg::dsmp_word_t CPU_STORE_ADDR,    // store address
  input wire logic                 CPU_LOAD_DONE,     // load done
  input wire logic                 CPU_STORE_DONE,    // store done
  input wire logic                 CPU_LOAD_MISS,     // load miss
  input wire dsmp_pkg::dsmp_word_t CPU_LOAD_DATA,     // load data
  input wire logic                 ACCESS_START,      // access start
  input wire logic                 ACCESS_WRITE,      // access is store
  input wire logic                 ACCESS_BUSY,       // access outstanding
  input wire dsmp_pkg::dsmp_word_t FABRIC_READ_DATA,  // fabric data
  input wire logic                 ACCESS_DONE_PULSE  // fabric completion
);
  // ---------------------------------------------------------------------------
  // port checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_ack_cause: assert property (DCR_ACK |-> $past(DCR_READ || DCR_WRITE) && !$past(PROC_RESET))
    else $error("register ack without a request");
  a_reload_init: assert property (PROC_RESET |=> CTRL_VALUE == $past(CTRL_INIT_VALUE)
    && REGION_VALUE == $past(REGION_INIT_VALUE))
    else $error("registers not reloaded");
  a_start_claim: assert property (ACCESS_START |-> $past(CPU_LOAD_REQ || CPU_STORE_REQ)
    && $past(CTRL_VALUE[0]) && $past(CPU_LOAD_REQ ? CPU_LOAD_ADDR[0:7]
    : CPU_STORE_ADDR[0:7]) == $past(REGION_VALUE))
    else $error("access started without a claim");
  a_load_first: assert property (ACCESS_START && $past(CPU_LOAD_REQ) |-> !ACCESS_WRITE)
    else $error("store served before pending load");
  a_start_spacing: assert property (ACCESS_START |=> !ACCESS_START [*2])
    else $error("access started too soon");
  a_done_retires: assert property (VARIANT_A && ACCESS_BUSY && ACCESS_DONE_PULSE |=>
    (CPU_LOAD_DONE || CPU_STORE_DONE) && !ACCESS_BUSY)
    else $error("completion did not retire access");
  a_wait_done: assert property (VARIANT_A && ACCESS_BUSY && !ACCESS_DONE_PULSE |=> ACCESS_BUSY
    && !CPU_LOAD_DONE && !CPU_STORE_DONE)
    else $error("access ended without completion");
  a_stray_ignored: assert property (VARIANT_A && !ACCESS_BUSY && ACCESS_DONE_PULSE |=>
    !CPU_LOAD_DONE && !CPU_STORE_DONE && $stable(CPU_LOAD_DATA))
    else $error("idle completion was not ignored");
  a_load_capture: assert property (CPU_LOAD_DONE |-> CPU_LOAD_DATA == $past(FABRIC_READ_DATA))
    else $error("load data not taken with completion");

  // main scenarios reached
  c_slow_load: cover property (ACCESS_START ##1 !ACCESS_DONE_PULSE [*3] ##1 ACCESS_DONE_PULSE);
  c_load_miss: cover property (CPU_LOAD_MISS);
  c_stray: cover property (!ACCESS_BUSY && ACCESS_DONE_PULSE && VARIANT_A);
endmodule

bind dsmp_port dsmp_port_asserts i_asserts (
  .CLK(CLK), .RST_B(RST_B), .PROC_RESET(PROC_RESET), .VARIANT_A(VARIANT_A),
  .CTRL_INIT_VALUE(CTRL_INIT_VALUE), .REGION_INIT_VALUE(REGION_INIT_VALUE),
  .DCR_READ(DCR_READ), .DCR_WRITE(DCR_WRITE), .DCR_ACK(DCR_ACK),
  .CTRL_VALUE(CTRL_VALUE), .REGION_VALUE(REGION_VALUE),
  .CPU_LOAD_REQ(CPU_LOAD_REQ), .CPU_LOAD_ADDR(CPU_LOAD_ADDR),
  .CPU_STORE_REQ(CPU_STORE_REQ), .CPU_STORE_ADDR(CPU_STORE_ADDR),
  .CPU_LOAD_DONE(CPU_LOAD_DONE), .CPU_STORE_DONE(CPU_STORE_DONE),
  .CPU_LOAD_MISS(CPU_LOAD_MISS), .CPU_LOAD_DATA(CPU_LOAD_DATA),
  .ACCESS_START(ACCESS_START), .ACCESS_WRITE(ACCESS_WRITE), .ACCESS_BUSY(ACCESS_BUSY),
  .FABRIC_READ_DATA(FABRIC_READ_DATA), .ACCESS_DONE_PULSE(ACCESS_DONE_PULSE)
);

// ### testbench/dsmp_port_bench.sv
`timescale 1ns/1ps

module dsmp_port_bench;
  import dsmp_pkg::*;
  logic       clk, rst_b, proc_reset, variant_a, ratio_ok, dcr_read, dcr_write, dcr_ack;
  logic       ld_req, st_req, ld_done, st_done, ld_miss, st_miss, a_start, a_write, a_busy;
  logic       done_p, tie_hi, stray;
  logic [3:0] ratio, delay;
  logic [0:5] hi6;
  logic [0:9] dcr_addr;
  dsmp_byte_t ctrl_init, region_init, hi8, wr_data, rd_data, ctrl_v, region_v;
  dsmp_word_t ld_addr, st_addr, ld_data, fab_data, rd_word;
  int         n_mismatch, checked;

  dsmp_port i_dut (.CLK(clk), .RST_B(rst_b), .PROC_RESET(proc_reset), .VARIANT_A(variant_a),
    .CLOCK_RATIO(ratio), .RATIO_OK(ratio_ok), .CTRL_INIT_VALUE(ctrl_init),
    .REGION_INIT_VALUE(region_init), .REG_ADDR_HI_EIGHT(hi8), .REG_ADDR_HI_SIX(hi6),
    .DCR_ADDR(dcr_addr), .DCR_READ(dcr_read), .DCR_WRITE(dcr_write), .DCR_WR_DATA(wr_data),
    .DCR_RD_DATA(rd_data), .DCR_ACK(dcr_ack), .CTRL_VALUE(ctrl_v), .REGION_VALUE(region_v),
    .CPU_LOAD_REQ(ld_req), .CPU_LOAD_ADDR(ld_addr), .CPU_STORE_REQ(st_req),
    .CPU_STORE_ADDR(st_addr), .CPU_LOAD_DONE(ld_done), .CPU_STORE_DONE(st_done),
    .CPU_LOAD_MISS(ld_miss), .CPU_STORE_MISS(st_miss), .CPU_LOAD_DATA(ld_data),
    .ACCESS_START(a_start), .ACCESS_WRITE(a_write), .ACCESS_BUSY(a_busy),
    .FABRIC_READ_DATA(fab_data), .ACCESS_DONE_PULSE(done_p));
  dsmp_fabric_model i_fabric (.clk(clk), .rst_b(rst_b), .start(a_start), .delay(delay),
    .tie_high(tie_hi), .stray(stray), .word(rd_word), .rd_data(fab_data), .done(done_p));

  // one clock drives port and fabric
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // sel 0 watches the start pulse, 1 load done, 2 store done
  task automatic wait_hi(input int sel);
    int   i;
    logic s;
    s = 1'h0;
    for (i = 0; i < 40 && s !== 1'h1; i++) begin
      tick();
      s = (sel == 0) ? a_start : ((sel == 1) ? ld_done : st_done);
    end
    if (s !== 1'h1) begin
      check("wait bound", 1'h0, 1'h1);
      print_verdict();
    end
  endtask

  task automatic reset_dut(input logic va, input logic [3:0] r);
    rst_b = 1'h0;
    variant_a = va;
    ratio = r;
    tie_hi = !va;
    repeat (3) tick();
    rst_b = 1'h1;
    repeat (2) tick();
  endtask

  task automatic dcr(input logic wr, input logic [0:9] a, input dsmp_byte_t d,
                     output logic ack, output dsmp_byte_t q);
    dcr_write = wr;
    dcr_read = !wr;
    dcr_addr = a;
    wr_data = d;
    tick();
    dcr_write = 1'h0;
    dcr_read = 1'h0;
    ack = dcr_ack;
    q = rd_data;
    tick();
  endtask

  // result: 1 done, 2 miss
  task automatic access(input logic ld, input dsmp_word_t a, input logic [3:0] dl,
                        input dsmp_word_t w, output logic [1:0] res);
    int i;
    delay = dl;
    rd_word = w;
    ld_addr = a;
    st_addr = a;
    ld_req = ld;
    st_req = !ld;
    res = 2'h0;
    for (i = 0; i < 40 && res == 2'h0; i++) begin
      tick();
      if (ld_done === 1'h1 || st_done === 1'h1) res = 2'h1;
      else if (ld_miss === 1'h1 || st_miss === 1'h1) res = 2'h2;
    end
    ld_req = 1'h0;
    st_req = 1'h0;
    if (res == 2'h0) begin
      check("access bound", res, 2'h1);
      print_verdict();
    end
    tick();
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic test_regs();
    logic       ack;
    dsmp_byte_t q;
    check("control init", ctrl_v, ctrl_init);
    check("region init", region_v, region_init);
    check("ratio in range", ratio_ok, 1'h1);
    dcr(1'h1, {hi6, 4'h6}, 8'h34, ack, q);
    check("region write ack", ack, 1'h1);
    check("region write", region_v, 8'h34);
    dcr(1'h0, {hi6, 4'h7}, 8'h00, ack, q);
    check("control read", q, ctrl_init);
    dcr(1'h1, {hi6, 4'h5}, 8'hff, ack, q);
    check("unmapped ack", ack, 1'h0);
    check("unmapped write", ctrl_v, ctrl_init);
  endtask

  task automatic test_access();
    logic [1:0] res;
    logic       ack;
    dsmp_byte_t q;
    access(1'h1, 32'h3400_0100, 4'h3, 32'hcafe_0001, res);
    check("slow load", res, 2'h1);
    check("load data", ld_data, 32'hcafe_0001);
    access(1'h0, 32'h3400_0104, 4'h0, 32'h0000_0000, res);
    check("fast store", res, 2'h1);
    stray = 1'h1;
    tick();
    stray = 1'h0;
    repeat (3) tick();
    check("stray ignored", ld_data, 32'hcafe_0001);
    access(1'h0, 32'h3500_0000, 4'h0, 32'h0000_0000, res);
    check("outside region", res, 2'h2);
    dcr(1'h1, {hi6, 4'h7}, 8'h00, ack, q);
    access(1'h1, 32'h3400_0000, 4'h0, 32'h0000_0000, res);
    check("decode off", res, 2'h2);
    dcr(1'h1, {hi6, 4'h7}, 8'h80, ack, q);
  endtask

  task automatic test_priority();
    delay = 4'h1;
    rd_word = 32'h1234_5678;
    ld_req = 1'h1;
    st_req = 1'h1;
    wait_hi(0);
    check("first access write", a_write, 1'h0);
    wait_hi(1);
    ld_req = 1'h0;
    check("priority load data", ld_data, 32'h1234_5678);
    wait_hi(2);
    st_req = 1'h0;
    tick();
  endtask

  task automatic test_variant_b();
    logic [1:0] res;
    logic       ack;
    dsmp_byte_t q;
    ctrl_init = 8'h82;
    region_init = 8'h56;
    proc_reset = 1'h1;
    tick();
    proc_reset = 1'h0;
    tick();
    check("control reload", ctrl_v, 8'h82);
    check("region reload", region_v, 8'h56);
    reset_dut(1'h0, 4'h5);
    check("ratio limit", ratio_ok, 1'h0);
    dcr(1'h0, {hi8, 2'h3}, 8'h00, ack, q);
    check("narrow control read", q, 8'h82);
    dcr(1'h1, {hi6, 4'h7}, 8'h00, ack, q);
    check("wide map refused", ack, 1'h0);
    access(1'h1, 32'h5600_0010, 4'h0, 32'h0bad_f00d, res);
    check("fixed latency load", res, 2'h1);
    check("fixed latency data", ld_data, 32'h0bad_f00d);
    dcr(1'h1, {hi8, 2'h2}, 8'h78, ack, q);
    check("narrow region write", region_v, 8'h78);
    dcr(1'h0, {hi8, 2'h2}, 8'h00, ack, q);
    check("narrow region read", q, 8'h78);
  endtask

  // main sequence
  initial begin
    n_mismatch = 0;
    checked = 0;
    {rst_b, proc_reset, dcr_read, dcr_write, ld_req, st_req, stray} = 7'h00;
    {variant_a, tie_hi, ratio, delay} = 10'h200;
    {ctrl_init, region_init, hi8, hi6} = 30'h2004_8401;
    {dcr_addr, wr_data, ld_addr, st_addr, rd_word} = 114'h0;
    ld_addr = 32'h3400_0200;
    st_addr = 32'h3400_0200;
    reset_dut(1'h1, 4'h8);
    test_regs();
    test_access();
    test_priority();
    test_variant_b();
    print_verdict();
  end
endmodule
